// ==== src/timer_pkg.sv ====
// Constants, field layout and carrier type of the gated 16-bit timer/counter
package timer_pkg;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_GATE = 8'h04;
	localparam logic [7:0] OFF_CLKSEL = 8'h08;
	localparam logic [7:0] OFF_COUNT_LOW = 8'h0c;
	localparam logic [7:0] OFF_COUNT_HIGH = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_OSC = 8'h18;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_RUN = 0;
	localparam int CTRL_WIDE = 1;
	localparam int CTRL_BYPASS = 2;
	localparam int CTRL_PS_LO = 4;
	localparam int GATE_POL = 6;
	localparam int GATE_ON = 7;
	localparam int STAT_FLAG = 0;
	localparam int STAT_OSC_OK = 1;
	localparam int OSC_ON = 0;
	// ----------------------------------------------------------------
	// Clock source codes
	// ----------------------------------------------------------------
	localparam logic [4:0] CS_PIN = 5'h00;
	localparam logic [4:0] CS_FOSC4 = 5'h01;
	localparam logic [4:0] CS_FOSC = 5'h02;
	localparam logic [4:0] CS_FAST = 5'h03;
	localparam logic [4:0] CS_SLOW = 5'h04;
	localparam logic [4:0] CS_MID = 5'h05;
	localparam logic [4:0] CS_LFOSC = 5'h06;
	localparam logic [4:0] CS_REF = 5'h07;
	localparam logic [4:0] CS_T0OVF = 5'h08;
	localparam logic [1:0] CS_CELL_TOP = 2'h2;
	// ----------------------------------------------------------------
	// Timing and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	// ----------------------------------------------------------------
	// Configuration carrier
	// ----------------------------------------------------------------
	typedef struct packed {
		logic run;
		logic wide;
		logic bypass;
		logic [1:0] ps;
		logic gating;
		logic pol;
		logic [4:0] cs;
		logic osc_on;
	} cfg_s;
	localparam cfg_s CFG_RST = '0;
endpackage

// ==== src/gated_16bit_timer_counter.sv ====
// Gated 16-bit timer/counter with prescaler, wide access buffer and APB slave
`timescale 1ns/1ns
`default_nettype none
module gated_16bit_timer_counter (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output var logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Count sources
	input wire logic ext_count_input,
	input wire logic fast_internal_osc,
	input wire logic slow_internal_osc,
	input wire logic mid_internal_osc,
	input wire logic secondary_low_freq_osc,
	input wire logic reference_clock_out,
	input wire logic timer0_overflow,
	input wire logic [7:0] logic_cell_output,
	// Gate, power state and oscillator status
	input wire logic gate_signal,
	input wire logic sleep_mode,
	input wire logic low_freq_osc_stable,
	// Status outputs
	output var logic low_freq_osc_on,
	output var logic rollover_flag,
	output var logic [15:0] count_value
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	timer_pkg::cfg_s cfg_ff, nxt_cfg;
	logic [15:0] count_ff, nxt_count;
	logic [7:0] hbuf_ff, nxt_hbuf;
	logic [2:0] ps_cnt_ff, nxt_ps_cnt;
	logic [1:0] div_ff, nxt_div;
	logic flag_ff, nxt_flag;
	logic armed_ff, nxt_armed;
	logic sync1_ff, sync2_ff, raw_ff, prev_ff;
	logic nxt_sync2;
	logic [31:0] rdata_ff, nxt_rdata;
	logic src, valid_src, internal_tick, lvl, rise, count_en, tick_in, tick_out;
	logic [2:0] ps_last;
	logic setup, wr, rd_setup, hit, wr_low, wr_high, cnt_wr, flag_clr;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Zero-wait slave; unmapped addresses answer with an error
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign rd_setup = setup & ~pwrite;
	assign hit = (paddr == timer_pkg::OFF_CTRL) | (paddr == timer_pkg::OFF_GATE) |
		(paddr == timer_pkg::OFF_CLKSEL) | (paddr == timer_pkg::OFF_COUNT_LOW) |
		(paddr == timer_pkg::OFF_COUNT_HIGH) | (paddr == timer_pkg::OFF_STATUS) |
		(paddr == timer_pkg::OFF_OSC);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign wr_low = wr & (paddr == timer_pkg::OFF_COUNT_LOW);
	assign wr_high = wr & (paddr == timer_pkg::OFF_COUNT_HIGH);
	assign cnt_wr = wr_low | wr_high;
	assign flag_clr = wr & (paddr == timer_pkg::OFF_STATUS) & pwdata[timer_pkg::STAT_FLAG];

	// ----------------------------------------------------------------
	// Source selection
	// ----------------------------------------------------------------
	// Pick the level of the selected source and the internal tick
	always_comb begin
		src = 1'b0;
		valid_src = 1'b1;
		internal_tick = 1'b0;
		case (cfg_ff.cs)
			timer_pkg::CS_PIN: src = ext_count_input;
			timer_pkg::CS_FOSC4: internal_tick = ~sleep_mode & (div_ff == timer_pkg::INSTR_DIV_LAST);
			timer_pkg::CS_FOSC: internal_tick = ~sleep_mode;
			timer_pkg::CS_FAST: src = fast_internal_osc;
			timer_pkg::CS_SLOW: src = slow_internal_osc;
			timer_pkg::CS_MID: src = mid_internal_osc;
			timer_pkg::CS_LFOSC: src = secondary_low_freq_osc & cfg_ff.osc_on;
			timer_pkg::CS_REF: src = reference_clock_out;
			timer_pkg::CS_T0OVF: src = timer0_overflow;
			default: begin
				if (cfg_ff.cs[4:3] == timer_pkg::CS_CELL_TOP) begin
					src = logic_cell_output[cfg_ff.cs[2:0]];
				end else begin
					valid_src = 1'b0;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Edge path
	// ----------------------------------------------------------------
	// Synchronised level freezes in sleep; bypassed level keeps going
	assign nxt_sync2 = (sleep_mode & ~cfg_ff.bypass) ? sync2_ff : sync1_ff;
	assign lvl = cfg_ff.bypass ? raw_ff : sync2_ff;
	assign rise = lvl & ~prev_ff;
	// Run, gate and polarity decide whether ticks reach the prescaler
	assign count_en = cfg_ff.run & (~cfg_ff.gating | (gate_signal == cfg_ff.pol));
	assign tick_in = count_en & valid_src & (internal_tick |
		(~internal_tick & cfg_ff.cs != timer_pkg::CS_FOSC4 & rise & ~armed_ff));
	// A count left above a new, smaller limit ends its period at once instead of wrapping
	assign ps_last = 3'((4'h1 << cfg_ff.ps) - 4'h1);
	assign tick_out = tick_in & (ps_cnt_ff >= ps_last);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Register file, prescaler, counter, flag and arm state
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_count = count_ff;
		nxt_hbuf = hbuf_ff;
		nxt_ps_cnt = ps_cnt_ff;
		nxt_div = div_ff + 2'd1;
		nxt_flag = flag_ff;
		nxt_armed = armed_ff;
		nxt_rdata = rdata_ff;
		if (!lvl) begin
			nxt_armed = 1'b0;
		end
		if (!cfg_ff.run || cnt_wr) begin
			nxt_armed = 1'b1;
		end
		if (tick_in) begin
			nxt_ps_cnt = tick_out ? 3'h0 : ps_cnt_ff + 3'h1;
		end
		if (tick_out) begin
			nxt_count = count_ff + 16'h0001;
		end
		if (flag_clr) begin
			nxt_flag = 1'b0;
		end
		if (tick_out && count_ff == timer_pkg::COUNT_MAX) begin
			nxt_flag = 1'b1;
		end
		// Reads are captured whole in the setup cycle
		if (rd_setup) begin
			case (paddr)
				timer_pkg::OFF_CTRL: nxt_rdata = 32'({cfg_ff.ps, 1'b0, cfg_ff.bypass,
					cfg_ff.wide, cfg_ff.run});
				timer_pkg::OFF_GATE: nxt_rdata = 32'({cfg_ff.gating, cfg_ff.pol, 6'h00});
				timer_pkg::OFF_CLKSEL: nxt_rdata = 32'(cfg_ff.cs);
				timer_pkg::OFF_COUNT_LOW: begin
					nxt_rdata = 32'(count_ff[7:0]);
					if (cfg_ff.wide) begin
						nxt_hbuf = count_ff[15:8];
					end
				end
				timer_pkg::OFF_COUNT_HIGH: nxt_rdata = 32'(cfg_ff.wide ? hbuf_ff : count_ff[15:8]);
				timer_pkg::OFF_STATUS: nxt_rdata = 32'({low_freq_osc_stable, flag_ff});
				timer_pkg::OFF_OSC: nxt_rdata = 32'(cfg_ff.osc_on);
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
		// Writes take effect at the access edge and win over counting, save a flag clear, which a rollover in the same cycle overrides
		if (wr) begin
			case (paddr)
				timer_pkg::OFF_CTRL: begin
					nxt_cfg.run = pwdata[timer_pkg::CTRL_RUN];
					nxt_cfg.wide = pwdata[timer_pkg::CTRL_WIDE];
					nxt_cfg.bypass = pwdata[timer_pkg::CTRL_BYPASS];
					nxt_cfg.ps = pwdata[timer_pkg::CTRL_PS_LO +: 2];
				end
				timer_pkg::OFF_GATE: begin
					nxt_cfg.pol = pwdata[timer_pkg::GATE_POL];
					nxt_cfg.gating = pwdata[timer_pkg::GATE_ON];
				end
				timer_pkg::OFF_CLKSEL: nxt_cfg.cs = pwdata[4:0];
				timer_pkg::OFF_COUNT_LOW: begin
					nxt_ps_cnt = 3'h0;
					if (cfg_ff.wide) begin
						nxt_count = {hbuf_ff, pwdata[7:0]};
						nxt_hbuf = count_ff[15:8];
					end else begin
						nxt_count = {count_ff[15:8], pwdata[7:0]};
					end
				end
				timer_pkg::OFF_COUNT_HIGH: begin
					if (cfg_ff.wide) begin
						nxt_hbuf = pwdata[7:0];
					end else begin
						nxt_count = {pwdata[7:0], count_ff[7:0]};
						nxt_ps_cnt = 3'h0;
					end
				end
				timer_pkg::OFF_OSC: nxt_cfg.osc_on = pwdata[timer_pkg::OSC_ON];
				default: nxt_cfg = cfg_ff;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Single clocked process; asynchronous reset to constants
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= timer_pkg::CFG_RST;
			count_ff <= timer_pkg::COUNT_RST;
			hbuf_ff <= 8'h00;
			ps_cnt_ff <= 3'h0;
			div_ff <= 2'h0;
			flag_ff <= 1'b0;
			armed_ff <= 1'b1;
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			raw_ff <= 1'b0;
			prev_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			cfg_ff <= nxt_cfg;
			count_ff <= nxt_count;
			hbuf_ff <= nxt_hbuf;
			ps_cnt_ff <= nxt_ps_cnt;
			div_ff <= nxt_div;
			flag_ff <= nxt_flag;
			armed_ff <= nxt_armed;
			sync1_ff <= src;
			sync2_ff <= nxt_sync2;
			raw_ff <= src;
			prev_ff <= lvl;
			rdata_ff <= nxt_rdata;
		end
	end

	// Outputs straight from flip-flops
	assign prdata = rdata_ff;
	assign rollover_flag = flag_ff;
	assign low_freq_osc_on = cfg_ff.osc_on;
	assign count_value = count_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	reserved_hold_a: assert property (!valid_src |-> !tick_in)
		else $error("reserved source produced a tick");
	fosc_count_a: assert property (cfg_ff.run && !cfg_ff.gating && cfg_ff.cs == timer_pkg::CS_FOSC
		&& !sleep_mode && cfg_ff.ps == 2'h0 && !cnt_wr |=> count_ff == $past(count_ff) + 16'h0001)
		else $error("fosc source did not advance every cycle");
	rollover_wrap_a: assert property (tick_out && count_ff == timer_pkg::COUNT_MAX && !cnt_wr
		|=> count_ff == 16'h0000 && flag_ff)
		else $error("rollover did not wrap and flag");
	flag_set_wins_a: assert property (tick_out && count_ff == timer_pkg::COUNT_MAX && flag_clr
		|=> flag_ff)
		else $error("flag clear beat a rollover");
	off_hold_a: assert property (!cfg_ff.run && !cnt_wr |=> $stable(count_ff))
		else $error("count moved while off");
	gate_hold_a: assert property (cfg_ff.run && cfg_ff.gating && gate_signal != cfg_ff.pol
		&& !cnt_wr |=> $stable(count_ff))
		else $error("count moved while gate inactive");
	write_arms_a: assert property (cnt_wr |=> armed_ff)
		else $error("count write did not require a falling edge");
	wide_read_a: assert property (rd_setup && cfg_ff.wide && paddr == timer_pkg::OFF_COUNT_LOW
		|=> hbuf_ff == $past(count_ff[15:8]) && prdata[7:0] == $past(count_ff[7:0]))
		else $error("low read did not latch high byte");
	wide_write_a: assert property (wr_low && cfg_ff.wide
		|=> count_ff == {$past(hbuf_ff), $past(pwdata[7:0])} && ps_cnt_ff == 3'h0)
		else $error("wide low write did not load both bytes");
	high_buffer_a: assert property (wr_high && cfg_ff.wide && !tick_in
		|=> hbuf_ff == $past(pwdata[7:0]) && $stable(ps_cnt_ff))
		else $error("wide high write touched prescaler or missed buffer");
	byte_clear_a: assert property (wr_high && !cfg_ff.wide |=> ps_cnt_ff == 3'h0)
		else $error("byte write kept prescaler");
	prescale_end_a: assert property (tick_in && ps_cnt_ff < ps_last |-> !tick_out)
		else $error("prescaler passed a tick early");

	rollover_c: cover property (tick_out && count_ff == timer_pkg::COUNT_MAX);
	wide_read_c: cover property (rd_setup && cfg_ff.wide && paddr == timer_pkg::OFF_COUNT_LOW);
	gated_c: cover property (cfg_ff.run && cfg_ff.gating && rise && gate_signal != cfg_ff.pol);
endmodule
`default_nettype wire

// ==== verif/count_src_model.sv ====
// Far-side model: external count pin and low-frequency oscillator
`timescale 1ns/1ns
`default_nettype none
module count_src_model (
	// Clock
	input wire logic pclk,
	// Controls
	input wire logic pin_go,
	input wire logic osc_on,
	// Driven levels
	output logic pin,
	output logic osc,
	output logic osc_ok
);
	int ph;
	int up;
	logic [1:0] ot;
	initial begin
		pin = 1'b0;
		osc = 1'b0;
		osc_ok = 1'b0;
		ph = 0;
		up = 0;
		ot = 2'h0;
	end
	// Pin toggles every third cycle inside a burst, rests low between bursts
	always @(posedge pclk) begin
		ph <= (ph == 2) ? 0 : ph + 1;
		pin <= pin_go ? (pin ^ (ph == 2)) : 1'b0;
	end
	// Oscillator runs while enabled, reports stable after a start-up delay
	always @(posedge pclk) begin
		up <= osc_on ? ((up < 8) ? up + 1 : up) : 0;
		ot <= ot + 2'h1;
		osc <= osc_on & ot[1]; // Quarter of pclk, keeps running once stable
		osc_ok <= (up == 8);
	end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench of the gated 16-bit timer/counter
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr, hb;
	logic [31:0] pwdata, prdata, rd_v, rnd;
	logic [1:0] tg;
	logic gate_signal, sleep_mode, pin, osc, osc_ok, osc_on, flag, pin_go;
	logic [15:0] count_value, a0;
	int err_count, n_tests, cyc, i, j;
	// ----------------------------------------------------------------
	// Clock, source pattern and timeout
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Shared internal source level, period of four cycles
	always @(posedge pclk) tg <= tg + 2'h1;
	// Cut a hang short
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			final_report();
		end
	end
	// ----------------------------------------------------------------
	// Instances
	// ----------------------------------------------------------------
	gated_16bit_timer_counter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_count_input(pin), .fast_internal_osc(tg[1]),
		.slow_internal_osc(tg[1]), .mid_internal_osc(tg[1]), .secondary_low_freq_osc(osc),
		.reference_clock_out(tg[1]), .timer0_overflow(tg[1]), .logic_cell_output({8{tg[1]}}),
		.gate_signal(gate_signal), .sleep_mode(sleep_mode), .low_freq_osc_stable(osc_ok),
		.low_freq_osc_on(osc_on), .rollover_flag(flag), .count_value(count_value));
	count_src_model src_u (.pclk(pclk), .pin_go(pin_go), .osc_on(osc_on), .pin(pin),
		.osc(osc), .osc_ok(osc_ok));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
	endfunction
	function automatic logic [31:0] ctl(input logic run, input logic wide, input logic byp,
		input logic [1:0] ps);
		logic [31:0] v;
		v = '0;
		v[timer_pkg::CTRL_RUN] = run;
		v[timer_pkg::CTRL_WIDE] = wide;
		v[timer_pkg::CTRL_BYPASS] = byp;
		v[timer_pkg::CTRL_PS_LO +: 2] = ps;
		return v;
	endfunction
	function automatic logic [31:0] gcfg(input logic on, input logic pol);
		logic [31:0] v;
		v = '0;
		v[timer_pkg::GATE_ON] = on;
		v[timer_pkg::GATE_POL] = pol;
		return v;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] x);
		n_tests++;
		if (got !== x) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, x);
		end
	endtask
	// One APB transfer; answer taken at the edge where pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd_v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rd_v, x);
	endtask
	// Count advance over a window of cycles, sampled away from the edge
	task automatic meas(input int n, input logic [15:0] x);
		logic [15:0] d16;
		repeat (16) @(posedge pclk);
		@(negedge pclk);
		a0 = count_value;
		repeat (n) @(negedge pclk);
		d16 = count_value - a0;
		chk({16'h0, d16}, {16'h0, x});
		@(posedge pclk);
	endtask
	task automatic final_report();
		if (err_count == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, gate_signal, sleep_mode, pin_go, presetn} = '0;
		paddr = '0;
		pwdata = '0;
		{err_count, n_tests, cyc} = '0;
		tg = '0;
		rnd = 32'h57e9;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(timer_pkg::OFF_CTRL, 32'h0); // Off after reset
		rd(timer_pkg::OFF_STATUS, 32'h0); // Flag clear after reset
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, e}, 32'h1);
		// Random byte-mode loads with live high-byte read back
		for (i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			wr(timer_pkg::OFF_COUNT_LOW, {24'h0, rnd[7:0]});
			wr(timer_pkg::OFF_COUNT_HIGH, {24'h0, rnd[15:8]});
			@(negedge pclk);
			chk({16'h0, count_value}, {16'h0, rnd[15:0]}); // Byte loads
			rd(timer_pkg::OFF_COUNT_HIGH, {24'h0, rnd[15:8]}); // Live byte
		end
		// System clock under every prescale setting, then its quarter with prescale 0
		wr(timer_pkg::OFF_CLKSEL, {27'h0, timer_pkg::CS_FOSC});
		for (i = 0; i < 4; i++) begin
			wr(timer_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, i[1:0]));
			meas(16 << i, 16'h10); // Divided count
		end
		wr(timer_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 2'h0));
		wr(timer_pkg::OFF_CLKSEL, {27'h0, timer_pkg::CS_FOSC4});
		meas(64, 16'h10); // Instruction clock
		// Every edge source but the pin, oscillator enabled and polled ready first
		wr(timer_pkg::OFF_OSC, 32'h1);
		for (j = 0; j < 100 && osc_ok !== 1'b1; j++) @(posedge pclk);
		rd(timer_pkg::OFF_STATUS, 32'h2); // Oscillator ready
		for (i = 3; i < 17; i++) begin
			wr(timer_pkg::OFF_CLKSEL, (i < 9) ? i : i + 7);
			meas(64, 16'h10); // Source selection
		end
		for (i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			wr(timer_pkg::OFF_CLKSEL, rnd[3] ? {27'h0, 5'h18 | rnd[2:0]} : {27'h0, 5'h0c | rnd[1:0]});
			meas(64, 16'h0); // Reserved code holds
		end
		// Pin source synchronised, then in sleep, then bypassed in sleep
		wr(timer_pkg::OFF_CLKSEL, {27'h0, timer_pkg::CS_PIN});
		pin_go <= 1'b1;
		meas(96, 16'h10); // Pin rises
		sleep_mode <= 1'b1;
		meas(96, 16'h0); // Sync path frozen
		wr(timer_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b1, 2'h0));
		meas(96, 16'h10); // Bypass keeps counting
		sleep_mode <= 1'b0;
		pin_go <= 1'b0;
		// Gate level and polarity table, then run bit
		wr(timer_pkg::OFF_CLKSEL, {27'h0, timer_pkg::CS_FOSC});
		wr(timer_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 2'h0));
		for (i = 0; i < 4; i++) begin
			wr(timer_pkg::OFF_GATE, gcfg(1'b1, i[1]));
			gate_signal <= i[0];
			meas(16, (i[0] == i[1]) ? 16'h10 : 16'h0); // Gated count
		end
		wr(timer_pkg::OFF_GATE, gcfg(1'b0, 1'b1));
		meas(16, 16'h10); // Always on
		wr(timer_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b0, 2'h0));
		meas(16, 16'h0); // Off
		// Wide access: buffered high byte on write and read
		rnd = lfsr(rnd);
		wr(timer_pkg::OFF_CTRL, ctl(1'b0, 1'b1, 1'b0, 2'h0));
		a0 = count_value;
		wr(timer_pkg::OFF_COUNT_HIGH, {24'h0, rnd[15:8]});
		chk({16'h0, count_value}, {16'h0, a0}); // Buffer only
		wr(timer_pkg::OFF_COUNT_LOW, {24'h0, rnd[7:0]});
		@(negedge pclk);
		chk({16'h0, count_value}, {16'h0, rnd[15:0]}); // Pair load
		wr(timer_pkg::OFF_COUNT_HIGH, {24'h0, rnd[23:16]});
		wr(timer_pkg::OFF_COUNT_LOW, 32'hf0);
		rd(timer_pkg::OFF_COUNT_LOW, 32'hf0); // Latch high byte
		wr(timer_pkg::OFF_CTRL, ctl(1'b1, 1'b1, 1'b0, 2'h0));
		repeat (40) @(posedge pclk);
		wr(timer_pkg::OFF_CTRL, ctl(1'b0, 1'b1, 1'b0, 2'h0));
		hb = rnd[23:16] + 8'h1;
		rd(timer_pkg::OFF_COUNT_HIGH, {24'h0, rnd[23:16]}); // Buffered read
		chk({24'h0, count_value[15:8]}, {24'h0, hb}); // Carry reached live byte
		// Rollover flag set and cleared
		wr(timer_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b0, 2'h0));
		wr(timer_pkg::OFF_COUNT_HIGH, 32'hff);
		wr(timer_pkg::OFF_COUNT_LOW, 32'hf0);
		wr(timer_pkg::OFF_STATUS, 32'h1);
		rd(timer_pkg::OFF_STATUS, 32'h2); // Flag clear
		wr(timer_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 2'h0));
		repeat (40) @(posedge pclk);
		wr(timer_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b0, 2'h0));
		rd(timer_pkg::OFF_STATUS, 32'h3); // Flag set on wrap
		chk({31'h0, flag}, 32'h1); // Flag output set
		chk({24'h0, count_value[15:8]}, 32'h0); // Wrapped to zero
		wr(timer_pkg::OFF_STATUS, 32'h1);
		rd(timer_pkg::OFF_STATUS, 32'h2); // Software clear
		chk({31'h0, flag}, 32'h0); // Flag output cleared
		final_report();
	end
endmodule
`default_nettype wire
